// ---- core_model.sv ----
// Processor core stand-in: enters presented requests and returns on command.
`timescale 1ns/1ps
module core_model (
  input  wire       clk_i,     // Clock.
  input  wire       rst_i,     // Reset.
  input  wire       req_i,     // Request from the arbiter.
  input  wire       take_en_i, // Entry allowed.
  input  wire [1:0] delay_i,   // Request cycles before entry.
  input  wire       ret_i,     // Return asked for.
  output reg        ack_o,     // Entry pulse.
  output reg        reti_o     // Return pulse.
);
  reg [1:0] wait_r;
  // A slow core restarts its count whenever the request drops.
  always @(posedge clk_i)
    if (rst_i)
    begin
      ack_o  <= 1'b0;
      reti_o <= 1'b0;
      wait_r <= 2'h0;
    end
    else
    begin
      ack_o  <= 1'b0;
      reti_o <= ret_i;
      if (!req_i || !take_en_i || ack_o)
        wait_r <= 2'h0;
      else if (wait_r == delay_i)
        ack_o <= 1'b1;
      else
        wait_r <= wait_r + 2'h1;
    end
endmodule // core_model

// ---- low_index_pick.v ----
// Finds the lowest set bit of a request vector.
`timescale 1ns/1ps
module low_index_pick #(
  parameter N  = 16,
  parameter IW = 4
) (
  input  wire [N-1:0]  req_i,  // Request vector.
  output reg           any_o,  // Some bit is set.
  output reg  [IW-1:0] idx_o   // Index of lowest set bit.
);
  integer i;
  always @*
  begin
    any_o = 1'b0;
    idx_o = {IW{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (req_i[i])
      begin
        any_o = 1'b1;
        idx_o = i[IW-1:0];
      end
    end
  end
endmodule // low_index_pick

// ---- pin_sync.v ----
// Two-flop synchroniser, one per bit, for pins entering the clock domain.
`timescale 1ns/1ps
module pin_sync #(
  parameter             WIDTH     = 7,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk_i,  // System clock.
  input  wire             rst_i,  // Synchronous reset, active high.
  input  wire [WIDTH-1:0] d_i,    // Asynchronous pin levels.
  output wire [WIDTH-1:0] q_o     // Synchronised levels.
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta_r <= RESET_VAL[g];
          sync_r <= RESET_VAL[g];
        end
        else
        begin
          meta_r <= d_i[g];
          sync_r <= meta_r;
        end
      end
      assign q_o[g] = sync_r;
    end
  endgenerate
endmodule // pin_sync

// ---- prio_irq_arbiter.v ----
// Interrupt arbiter with flags, enables, three levels, vectoring and a Wishbone slave.
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "prio_irq_defines.vh"
module prio_irq_arbiter (
  input  wire        clk_i,               // System clock, 200 MHz.
  input  wire        rst_i,               // Synchronous reset, active high.
  input  wire        wb_cyc_i,            // Wishbone cycle.
  input  wire        wb_stb_i,            // Wishbone strobe.
  input  wire        wb_we_i,             // Wishbone write enable.
  input  wire [7:0]  wb_adr_i,            // Wishbone byte address.
  input  wire [3:0]  wb_sel_i,            // Wishbone byte selects.
  input  wire [31:0] wb_dat_i,            // Wishbone write data.
  output reg  [31:0] wb_dat_o,            // Wishbone read data.
  output reg         wb_ack_o,            // Wishbone acknowledge.
  input  wire        power_fail_warn_i,   // Supply warning pin, high when low supply.
  input  wire [5:0]  ext_pin_n_i,         // External interrupt pins 0..5, active low.
  input  wire        timer_a_ovf_i,       // Timer A overflow pulse.
  input  wire        timer_b_ovf_i,       // Timer B overflow pulse.
  input  wire        timer_c_ovf_i,       // Timer C overflow pulse.
  input  wire        serial_a_rx_i,       // Serial A receive flag level.
  input  wire        serial_a_tx_i,       // Serial A transmit flag level.
  input  wire        serial_b_rx_i,       // Serial B receive flag level.
  input  wire        serial_b_tx_i,       // Serial B transmit flag level.
  input  wire        can_a_irq_i,         // CAN A request level.
  input  wire        can_b_irq_i,         // CAN B request level.
  input  wire        can_activity_irq_i,  // CAN bus activity request level.
  input  wire        watchdog_warn_i,     // Watchdog warning pulse.
  input  wire        core_ack_i,          // Core enters the presented service.
  input  wire        core_reti_i,         // Core returns from a service.
  output reg         core_irq_req_o,      // Request to the core.
  output reg  [7:0]  core_vector_o,       // Vector of the presented request.
  output reg  [1:0]  core_level_o,        // Level of the presented request.
  output wire        irq_o                // Summary interrupt, active high.
);
  // Synchronised pins: bit 6 power fail, bits 5..0 external pins.
  wire [6:0] pin_s;
  pin_sync #(
    .WIDTH     (7),
    .RESET_VAL (7'h3f)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({power_fail_warn_i, ext_pin_n_i}),
    .q_o   (pin_s)
  );

  reg  [7:0]  irq_enable_reg_r;
  reg  [7:0]  irq_priority_reg_r;
  reg  [7:0]  ext_irq_enable_reg_r;
  reg  [7:0]  ext_irq_priority_reg_r;
  reg         ext0_mode_r;
  reg         ext1_mode_r;
  reg         ext0_pending_r;
  reg         ext1_pending_r;
  reg         timer_a_overflow_r;
  reg         timer_b_overflow_r;
  reg         timer_c_overflow_r;
  reg  [3:0]  ext_hi_pending_r;
  reg         power_fail_request_r;
  reg         power_fail_request_en_r;
  reg         watchdog_warning_flag_r;
  reg  [6:0]  pin_prev_r;
  reg  [2:0]  int_status_r;
  reg  [2:0]  int_mask_r;
  reg  [2:0]  in_service_r;
  reg  [3:0]  idx_r;

  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr     = wb_req & wb_we_i & wb_sel_i[0];
  wire [7:0]  wd     = wb_dat_i[7:0];
  wire        wr_ie  = wr & (wb_adr_i == `OFS_IRQ_ENABLE);
  wire        wr_ip  = wr & (wb_adr_i == `OFS_IRQ_PRIORITY);
  wire        wr_eie = wr & (wb_adr_i == `OFS_EXT_IRQ_ENABLE);
  wire        wr_eip = wr & (wb_adr_i == `OFS_EXT_IRQ_PRIO);
  wire        wr_tc  = wr & (wb_adr_i == `OFS_TIMER_CTRL);
  wire        wr_wd  = wr & (wb_adr_i == `OFS_WATCHDOG_CTRL);
  wire        wr_xf  = wr & (wb_adr_i == `OFS_EXT_FLAGS);
  wire        wr_st  = wr & (wb_adr_i == `OFS_INT_STATUS);
  wire        wr_mk  = wr & (wb_adr_i == `OFS_INT_MASK);

  wire        global_irq_gate = irq_enable_reg_r[`BIT_GLOBAL_GATE];
  wire        ext_zero_en     = irq_enable_reg_r[0];
  wire        serial_a_irq_en = irq_enable_reg_r[4];
  wire        serial_b_irq_en = irq_enable_reg_r[6];
  wire        watchdog_warning_en = ext_irq_enable_reg_r[4];
  wire        can_a_irq_en        = ext_irq_enable_reg_r[6];
  wire        can_b_irq_en        = ext_irq_enable_reg_r[5];
  wire        can_activity_irq_en = ext_irq_enable_reg_r[7];

  // Falling edges of the active-low external pins.
  wire [5:0]  ext_fall = pin_prev_r[5:0] & ~pin_s[5:0];
  wire        pfail_rise = pin_s[6] & ~pin_prev_r[6];

  // Service entry clears the automatic flags (timers A and B, edge-mode externals 0 and 1) of the source being entered.
  wire [15:0] entry_clr = core_ack_i ? (16'h0001 << idx_r) : 16'h0000;

  // Pending flags in natural order.
  wire [15:0] pend;
  assign pend[0]  = power_fail_request_r;
  assign pend[1]  = ext0_pending_r;
  assign pend[2]  = timer_a_overflow_r;
  assign pend[3]  = ext1_pending_r;
  assign pend[4]  = timer_b_overflow_r;
  assign pend[5]  = serial_a_rx_i | serial_a_tx_i;
  assign pend[6]  = timer_c_overflow_r;
  assign pend[7]  = serial_b_rx_i | serial_b_tx_i;
  assign pend[11:8] = ext_hi_pending_r;
  assign pend[12] = can_a_irq_i;
  assign pend[13] = can_b_irq_i;
  assign pend[14] = watchdog_warning_flag_r;
  assign pend[15] = can_activity_irq_i;

  // Enables and priority selects in natural order.
  wire [15:0] en = {can_activity_irq_en, watchdog_warning_en, can_b_irq_en, can_a_irq_en,
                    ext_irq_enable_reg_r[3:0], serial_b_irq_en, irq_enable_reg_r[5],
                    serial_a_irq_en, irq_enable_reg_r[3:1], ext_zero_en,
                    power_fail_request_en_r};
  wire [15:0] prio = {ext_irq_priority_reg_r[7], ext_irq_priority_reg_r[4],
                      ext_irq_priority_reg_r[5], ext_irq_priority_reg_r[6],
                      ext_irq_priority_reg_r[3:0], irq_priority_reg_r[6],
                      irq_priority_reg_r[7], irq_priority_reg_r[4:0], 1'b0};

  // Maskable sources need both their enable and the global gate.
  wire [15:0] req = pend & en & {{15{global_irq_gate}}, 1'b1};
  wire [15:0] hi_req = req & prio & 16'hfffe;
  wire [15:0] lo_req = req & ~prio & 16'hfffe;

  wire        hi_any;
  wire [3:0]  hi_idx;
  wire        lo_any;
  wire [3:0]  lo_idx;
  low_index_pick #(
    .N  (16),
    .IW (4)
  ) u_pick_hi (
    .req_i (hi_req),
    .any_o (hi_any),
    .idx_o (hi_idx)
  );
  low_index_pick #(
    .N  (16),
    .IW (4)
  ) u_pick_lo (
    .req_i (lo_req),
    .any_o (lo_any),
    .idx_o (lo_idx)
  );

  // Level 3 is power fail only, then high, then low; natural order within a level.
  reg  [1:0]  cand_lvl;
  reg  [3:0]  cand_idx;
  always @*
  begin
    if (req[0])
    begin
      cand_lvl = 2'h3;
      cand_idx = 4'h0;
    end
    else if (hi_any)
    begin
      cand_lvl = 2'h2;
      cand_idx = hi_idx;
    end
    else if (lo_any)
    begin
      cand_lvl = 2'h1;
      cand_idx = lo_idx;
    end
    else
    begin
      cand_lvl = 2'h0;
      cand_idx = 4'h0;
    end
  end

  wire [1:0]  run_lvl = in_service_r[2] ? 2'h3 :
                        in_service_r[1] ? 2'h2 :
                        in_service_r[0] ? 2'h1 : 2'h0;
  wire        cand_ok = (cand_lvl > run_lvl);

  reg  [7:0]  cand_vec;
  always @*
  begin
    case (cand_idx)
      4'h0:    cand_vec = `VEC_PFAIL;
      4'h1:    cand_vec = `VEC_EXT0;
      4'h2:    cand_vec = `VEC_TIMER_A;
      4'h3:    cand_vec = `VEC_EXT1;
      4'h4:    cand_vec = `VEC_TIMER_B;
      4'h5:    cand_vec = `VEC_SERIAL_A;
      4'h6:    cand_vec = `VEC_TIMER_C;
      4'h7:    cand_vec = `VEC_SERIAL_B;
      4'h8:    cand_vec = `VEC_EXT2;
      4'h9:    cand_vec = `VEC_EXT3;
      4'ha:    cand_vec = `VEC_EXT4;
      4'hb:    cand_vec = `VEC_EXT5;
      4'hc:    cand_vec = `VEC_CAN_A;
      4'hd:    cand_vec = `VEC_CAN_B;
      4'he:    cand_vec = `VEC_WDOG;
      default: cand_vec = `VEC_CAN_ACT;
    endcase
  end

  // Presented request; dropped the cycle after an entry so the core sees fresh state.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_irq_req_o <= 1'b0;
      core_vector_o  <= `RST_REG8;
      core_level_o   <= 2'h0;
      idx_r          <= 4'h0;
    end
    else
    begin
      core_irq_req_o <= cand_ok & ~core_ack_i;
      core_vector_o  <= cand_vec;
      core_level_o   <= cand_lvl;
      idx_r          <= cand_idx;
    end
  end

  // In-service levels; a return closes the highest level open.
  wire [2:0]  reti_clr = ~core_reti_i    ? 3'h0 :
                         in_service_r[2] ? 3'h4 :
                         in_service_r[1] ? 3'h2 : 3'h1;
  wire [2:0]  entry_set = ~core_ack_i ? 3'h0 :
                          (core_level_o == 2'h3) ? 3'h4 :
                          (core_level_o == 2'h2) ? 3'h2 : 3'h1;
  wire [2:0]  ev = {core_ack_i & (in_service_r != 3'h0), pfail_rise, core_ack_i};

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_service_r <= `RST_STATUS3;
      int_status_r <= `RST_STATUS3;
      int_mask_r   <= `RST_STATUS3;
      pin_prev_r   <= 7'h3f;
    end
    else
    begin
      in_service_r <= (in_service_r & ~reti_clr) | entry_set;
      // Write one to clear; a new event in the same cycle wins.
      int_status_r <= (int_status_r & ~(wr_st ? wd[2:0] : 3'h0)) | ev;
      if (wr_mk)
        int_mask_r <= wd[2:0];
      pin_prev_r <= pin_s;
    end
  end
  assign irq_o = |(int_status_r & int_mask_r);

  // Control registers written by software.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_enable_reg_r        <= `RST_REG8;
      irq_priority_reg_r      <= `RST_REG8;
      ext_irq_enable_reg_r    <= `RST_REG8;
      ext_irq_priority_reg_r  <= `RST_REG8;
      ext0_mode_r             <= 1'b0;
      ext1_mode_r             <= 1'b0;
      power_fail_request_en_r <= 1'b0;
    end
    else
    begin
      if (wr_ie)
        irq_enable_reg_r <= wd;
      if (wr_ip)
        irq_priority_reg_r <= wd;
      if (wr_eie)
        ext_irq_enable_reg_r <= wd;
      if (wr_eip)
        ext_irq_priority_reg_r <= wd;
      if (wr_tc)
      begin
        ext0_mode_r <= wd[`BIT_EXT0_MODE];
        ext1_mode_r <= wd[`BIT_EXT1_MODE];
      end
      if (wr_wd)
        power_fail_request_en_r <= wd[`BIT_PFAIL_EN];
    end
  end

  // Pending flags: software writes, hardware sets win, entry clears where automatic.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext0_pending_r          <= 1'b0;
      ext1_pending_r          <= 1'b0;
      timer_a_overflow_r      <= 1'b0;
      timer_b_overflow_r      <= 1'b0;
      timer_c_overflow_r      <= 1'b0;
      ext_hi_pending_r        <= 4'h0;
      power_fail_request_r    <= 1'b0;
      watchdog_warning_flag_r <= 1'b0;
    end
    else
    begin
      if (ext0_mode_r)
        ext0_pending_r <= ((wr_tc ? wd[`BIT_EXT0_PEND] : ext0_pending_r) & ~entry_clr[1])
                          | ext_fall[0];
      else
        ext0_pending_r <= ~pin_s[0];
      if (ext1_mode_r)
        ext1_pending_r <= ((wr_tc ? wd[`BIT_EXT1_PEND] : ext1_pending_r) & ~entry_clr[3])
                          | ext_fall[1];
      else
        ext1_pending_r <= ~pin_s[1];
      timer_a_overflow_r <= ((wr_tc ? wd[`BIT_TIMER_A_OVF] : timer_a_overflow_r)
                             & ~entry_clr[2]) | timer_a_ovf_i;
      timer_b_overflow_r <= ((wr_tc ? wd[`BIT_TIMER_B_OVF] : timer_b_overflow_r)
                             & ~entry_clr[4]) | timer_b_ovf_i;
      // These flags are cleared only by software.
      timer_c_overflow_r <= (wr_xf ? wd[`BIT_TIMER_C_OVF] : timer_c_overflow_r)
                            | timer_c_ovf_i;
      ext_hi_pending_r <= (wr_xf ? wd[`BIT_EXT2_PEND+3:`BIT_EXT2_PEND] : ext_hi_pending_r)
                          | ext_fall[5:2];
      power_fail_request_r <= (wr_wd ? wd[`BIT_PFAIL_FLAG] : power_fail_request_r)
                              | pin_s[6];
      watchdog_warning_flag_r <= (wr_wd ? wd[`BIT_WDOG_FLAG] : watchdog_warning_flag_r)
                                 | watchdog_warn_i;
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  reg  [31:0] rd;
  always @*
  begin
    rd = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_IRQ_ENABLE:     rd[7:0] = irq_enable_reg_r;
      `OFS_IRQ_PRIORITY:   rd[7:0] = irq_priority_reg_r;
      `OFS_EXT_IRQ_ENABLE: rd[7:0] = ext_irq_enable_reg_r;
      `OFS_EXT_IRQ_PRIO:   rd[7:0] = ext_irq_priority_reg_r;
      `OFS_TIMER_CTRL:     rd[7:0] = {timer_b_overflow_r, 1'b0, timer_a_overflow_r, 1'b0,
                                      ext1_pending_r, ext1_mode_r, ext0_pending_r,
                                      ext0_mode_r};
      `OFS_WATCHDOG_CTRL:  rd[7:0] = {2'h0, power_fail_request_en_r, power_fail_request_r,
                                      watchdog_warning_flag_r, 3'h0};
      `OFS_EXT_FLAGS:      rd[7:0] = {ext_hi_pending_r, 3'h0, timer_c_overflow_r};
      `OFS_PENDING:        rd[15:0] = pend;
      `OFS_INT_STATUS:     rd[2:0] = int_status_r;
      `OFS_INT_MASK:       rd[2:0] = int_mask_r;
      `OFS_SERVICE:        rd[6:0] = {idx_r, in_service_r};
      default:             rd = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd : 32'h0000_0000;
    end
  end
endmodule // prio_irq_arbiter

// ---- prio_irq_arbiter_assertions.sv ----
// Concurrent checks on the ports of the interrupt arbiter.
`timescale 1ns/1ps
module prio_irq_arbiter_assertions (
  input wire        clk_i,          // Clock.
  input wire        rst_i,          // Reset.
  input wire        wb_cyc_i,       // Bus cycle.
  input wire        wb_stb_i,       // Bus strobe.
  input wire [31:0] wb_dat_o,       // Read data.
  input wire        wb_ack_o,       // Bus acknowledge.
  input wire        core_ack_i,     // Service entry.
  input wire        core_reti_i,    // Service return.
  input wire        core_irq_req_o, // Core request.
  input wire [7:0]  core_vector_o,  // Vector.
  input wire [1:0]  core_level_o,   // Level.
  input wire        irq_o           // Summary interrupt.
);
  reg [1:0] run_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Level of the open service; the bench never nests two entries.
  always @(posedge clk_i)
    if (rst_i || core_reti_i)
      run_r <= 2'h0;
    else if (core_ack_i && core_irq_req_o)
      run_r <= core_level_o;
  property p_bus_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer is not a one-cycle ack");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_dat_upper; wb_ack_o |-> wb_dat_o[31:16] == 16'h0; endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("upper read bits set");
  property p_top_pfail; core_irq_req_o && core_level_o == 2'h3 |-> core_vector_o == 8'h33; endproperty
  a_top_pfail: assert property (p_top_pfail) else $error("top level not power fail");
  property p_pfail_top; core_irq_req_o && core_vector_o == 8'h33 |-> core_level_o == 2'h3; endproperty
  a_pfail_top: assert property (p_pfail_top) else $error("power fail not at top");
  property p_vec_set; core_irq_req_o |-> core_vector_o[2:0] == 3'h3 && core_vector_o <= 8'h7b; endproperty
  a_vec_set: assert property (p_vec_set) else $error("vector outside table");
  property p_no_equal; core_irq_req_o |-> core_level_o > run_r; endproperty
  a_no_equal: assert property (p_no_equal) else $error("request not above running level");
  property p_ack_drop; core_irq_req_o && core_ack_i |=> !core_irq_req_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after entry");
  property p_rst_out; $fell(rst_i) |-> !core_irq_req_o && !wb_ack_o && !irq_o; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
  c_top: cover property (core_ack_i && core_level_o == 2'h3);
  c_high: cover property (core_ack_i && core_level_o == 2'h2);
  c_irq: cover property (irq_o && wb_ack_o);
endmodule // prio_irq_arbiter_assertions

// ---- prio_irq_defines.vh ----
// Constants for the prioritized interrupt arbiter: offsets, bit positions, vectors, resets.
// Function
// - Sixteen interrupt sources are arbitrated over three priority levels.
// - Every source but power fail requests only when its own enable and the global gate are set.
// - With the global gate clear no maskable source is taken, whatever its own enable.
// - The topmost level belongs to power fail alone and no other source can reach it.
// - Each maskable source has a priority bit where 1 means high and 0 means low.
// - Among pending sources of one level the lowest natural number, 0 to 15, wins.
// - Each source has a pending flag, enable, natural rank and (but power fail) a priority bit.
// - Serial port A raises one request from its transmit or receive flag, vector 23h, enable bit 4.
// - Serial port B raises one request from its transmit or receive flag, vector 3Bh, enable bit 6.
// - Timer A and timer B overflow flags clear in hardware on entry to their service.
// - External 0 and 1 flags in edge mode clear in hardware on entry to their service.
// - External 0 and 1 flags in level mode follow the current pin level instead of latching.
// - An enabled power-fail warning vectors the processor to 0033h.
// - The power-fail flag is set by the warning whatever its enable and software clears it.
`ifndef PRIO_IRQ_DEFINES_VH
`define PRIO_IRQ_DEFINES_VH
`define OFS_IRQ_ENABLE      8'h00
`define OFS_IRQ_PRIORITY    8'h04
`define OFS_EXT_IRQ_ENABLE  8'h08
`define OFS_EXT_IRQ_PRIO    8'h0c
`define OFS_TIMER_CTRL      8'h10
`define OFS_WATCHDOG_CTRL   8'h14
`define OFS_EXT_FLAGS       8'h18
`define OFS_PENDING         8'h1c
`define OFS_INT_STATUS      8'h20
`define OFS_INT_MASK        8'h24
`define OFS_SERVICE         8'h28
`define BIT_GLOBAL_GATE     7
`define BIT_EXT0_MODE       0
`define BIT_EXT0_PEND       1
`define BIT_EXT1_MODE       2
`define BIT_EXT1_PEND       3
`define BIT_TIMER_A_OVF     5
`define BIT_TIMER_B_OVF     7
`define BIT_WDOG_FLAG       3
`define BIT_PFAIL_FLAG      4
`define BIT_PFAIL_EN        5
`define BIT_TIMER_C_OVF     0
`define BIT_EXT2_PEND       4
`define ST_ENTRY            0
`define ST_PFAIL            1
`define ST_PREEMPT          2
`define RST_REG8            8'h00
`define RST_STATUS3         3'h0
`define VEC_PFAIL           8'h33
`define VEC_EXT0            8'h03
`define VEC_TIMER_A         8'h0b
`define VEC_EXT1            8'h13
`define VEC_TIMER_B         8'h1b
`define VEC_SERIAL_A        8'h23
`define VEC_TIMER_C         8'h2b
`define VEC_SERIAL_B        8'h3b
`define VEC_EXT2            8'h43
`define VEC_EXT3            8'h4b
`define VEC_EXT4            8'h53
`define VEC_EXT5            8'h5b
`define VEC_CAN_A           8'h6b
`define VEC_CAN_B           8'h73
`define VEC_WDOG            8'h63
`define VEC_CAN_ACT         8'h7b
`endif

// ---- prioritized_interrupt_arbiter_bench.sv ----
// Self-checking bench for the interrupt arbiter with a core stand-in.
`timescale 1ns/1ps
module prioritized_interrupt_arbiter_bench;
  reg         clk_i, rst_i, wb_cyc, wb_stb, wb_we, take_en, ret_go, g;
  reg         pf, ta, tb, tc, sa_rx, sa_tx, sb_rx, sb_tx, ca, cb, cact, wd;
  reg  [7:0]  wb_adr, vt[16];
  reg  [31:0] wb_dat, q;
  reg  [15:0] en, pr, sm, p;
  reg  [5:0]  xp;
  reg  [1:0]  dly, lvl;
  wire [31:0] rdat;
  wire [7:0]  vec;
  wire        ack, req, irq, c_ack, c_reti;
  int         n_mismatch, check_count, k, w, n, eb[16];
  prio_irq_arbiter dut (.clk_i, .rst_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .power_fail_warn_i(pf), .ext_pin_n_i(xp), .timer_a_ovf_i(ta), .timer_b_ovf_i(tb),
    .timer_c_ovf_i(tc), .serial_a_rx_i(sa_rx), .serial_a_tx_i(sa_tx), .serial_b_rx_i(sb_rx),
    .serial_b_tx_i(sb_tx), .can_a_irq_i(ca), .can_b_irq_i(cb), .can_activity_irq_i(cact),
    .watchdog_warn_i(wd), .core_ack_i(c_ack), .core_reti_i(c_reti), .core_irq_req_o(req),
    .core_vector_o(vec), .core_level_o(lvl), .irq_o(irq));
  core_model core (.clk_i, .rst_i, .req_i(req), .take_en_i(take_en), .delay_i(dly),
    .ret_i(ret_go), .ack_o(c_ack), .reti_o(c_reti));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wb(input bit we, input [7:0] a, input [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
    if (ack !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop;
    end
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Waits for the request (0) or for the core's entry (1).
  task wait_on(input bit which);
    int i;
    for (i = 0; i < 40 && (which ? c_ack : req) !== 1'b1; i++) @(posedge clk_i);
    if (i == 40)
    begin
      n_mismatch++;
      report_and_stop;
    end
  endtask
  task enter_ret(input bit ret);
    if (ret)
    begin
      ret_go <= 1'b1;
      @(posedge clk_i);
      ret_go <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    else
    begin
      take_en <= 1'b1;
      wait_on(1'b1);
      take_en <= 1'b0;
    end
  endtask
  // Highest level first; the downward loop makes the lowest index win ties.
  function automatic int win(input [15:0] pv);
    int i;
    int b;
    b = -1;
    for (i = 15; i >= 0; i--)
      if (pv[i] && g && en[eb[i]] && (b < 0 || pr[eb[i]] >= pr[eb[b]]))
        b = i;
    return b;
  endfunction
  initial
  begin
    {wb_cyc, wb_stb, wb_we, pf, ta, tb, tc, wd, take_en, ret_go} = 10'h0;
    {sa_rx, sa_tx, sb_rx, sb_tx, ca, cb, cact} = 7'h0;
    xp = 6'h3f;
    {wb_adr, wb_dat, dly, n_mismatch, check_count} = '0;
    rst_i = 1'b1;
    eb = '{0, 0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 14, 13, 12, 15};
    vt = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h3b,
           8'h43, 8'h4b, 8'h53, 8'h5b, 8'h6b, 8'h73, 8'h63, 8'h7b};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    q = $urandom(44);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h30, 32'h0);
    chk(q, 32'h0);
    // External 0: level mode follows the pin, edge mode latches and clears on entry.
    xp <= 6'h3e;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h2);
    xp <= 6'h3f;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h10, 32'h1);
    wb(1'b1, 8'h00, 32'h81);
    xp <= 6'h3e;
    wait_on(1'b0);
    chk(vec, 32'h3);
    enter_ret(1'b0);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h1);
    xp <= 6'h3f;
    enter_ret(1'b1);
    for (k = 0; k < 6; k++)
    begin
      en = k ? $urandom : 16'hffff;
      pr = $urandom;
      pr[7] = pr[5];
      sm = k ? $urandom : 16'hffff;
      g = (k != 2);
      wb(1'b1, 8'h00, {24'h0, g, en[6:0]});
      wb(1'b1, 8'h08, {24'h0, en[15:8]});
      wb(1'b1, 8'h04, {24'h0, pr[7:0]});
      wb(1'b1, 8'h0c, {24'h0, pr[15:8]});
      {sb_rx, sa_tx, cact, cb, ca, sb_tx, sa_rx, wd, tc, tb, ta} <= sm[10:0];
      p = {sm[8], sm[3], sm[7], sm[6], 4'h0, sm[5] | sm[10], sm[2], sm[4] | sm[9], sm[1],
           1'b0, sm[0], 2'h0};
      @(posedge clk_i);
      {wd, tc, tb, ta} <= 4'h0;
      repeat (4) @(posedge clk_i);
      wb(1'b0, 8'h1c, 32'h0);
      chk(q, {16'h0, p});
      w = win(p);
      for (n = 0; w >= 0 && n < 12; n++)
      begin
        wait_on(1'b0);
        chk(vec, vt[w]);
        chk(lvl, pr[eb[w]] ? 32'h2 : 32'h1);
        dly <= 2'($urandom);
        enter_ret(1'b0);
        p[w] = 1'b0;
        case (w)
          5: {sa_rx, sa_tx} <= 2'h0;
          7: {sb_rx, sb_tx} <= 2'h0;
          12: ca <= 1'b0;
          13: cb <= 1'b0;
          15: cact <= 1'b0;
          6: wb(1'b1, 8'h18, 32'h0);
          14: wb(1'b1, 8'h14, 32'h0);
          default: ;
        endcase
        wb(1'b0, 8'h1c, 32'h0);
        chk(q, {16'h0, p});
        enter_ret(1'b1);
        w = win(p);
      end
      repeat (4) @(posedge clk_i);
      chk(req, 32'h0);
      {sa_rx, sa_tx, sb_rx, sb_tx, ca, cb, cact} <= 7'h0;
      wb(1'b1, 8'h10, 32'h0);
      wb(1'b1, 8'h18, 32'h0);
      wb(1'b1, 8'h14, 32'h0);
      wb(1'b1, 8'h20, 32'hff);
    end
    wb(1'b1, 8'h00, 32'h0);
    pf <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(req, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h10);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h2);
    chk(irq, 32'h0);
    wb(1'b1, 8'h24, 32'h2);
    chk(irq, 32'h1);
    wb(1'b1, 8'h14, 32'h30);
    wait_on(1'b0);
    chk(vec, 32'h33);
    chk(lvl, 32'h3);
    enter_ret(1'b0);
    pf <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, 8'h14, 32'h0);
    enter_ret(1'b1);
    wb(1'b1, 8'h20, 32'h7);
    chk(irq, 32'h0);
    report_and_stop;
  end
endmodule // prioritized_interrupt_arbiter_bench
bind prio_irq_arbiter prio_irq_arbiter_assertions chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .core_ack_i, .core_reti_i, .core_irq_req_o, .core_vector_o,
  .core_level_o, .irq_o);
